// ### design/alarm_and_dac_readback.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_and_dac_readback (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire alarm_readback_pkg::alarm_cause_t cause_i,
    input  wire logic                         alarm_clear_i,
    input  wire logic                         conv_valid_i,
    input  wire alarm_readback_pkg::convert_req_t conv_req_i,
    output var  logic [23:0]                  alarm_status_word_o,
    output var  logic [23:0]                  conv_word_o,
    output var  logic                         conv_done_o,
    output var  logic                         conv_refused_o,
    output var  logic                         temp_alarm_pin_out_o,
    output var  logic                         temp_alarm_pin_oe_o,
    output var  logic                         clamp_guard_alarm_pin_out_o,
    output var  logic                         clamp_guard_alarm_pin_oe_o
);
    import alarm_readback_pkg::*;

    logic                temp_over;
    logic                latched_temp_alarm;
    logic                live_temp_alarm;
    logic [CHANNELS-1:0] latched_guard_alarm_n;
    logic [CHANNELS-1:0] live_guard_alarm_n;
    logic [CHANNELS-1:0] latched_clamp_alarm_n;
    logic [CHANNELS-1:0] live_clamp_alarm_n;

    assign temp_over = cause_i.temp_code > cause_i.temp_threshold;

    alarm_flag_pair u_temp (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .cond_i    (temp_over),
        .clear_i   (alarm_clear_i),
        .latched_o (latched_temp_alarm),
        .live_o    (live_temp_alarm)
    );

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        alarm_flag_pair u_guard (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .cond_i    (cause_i.guard_fault[ch]),
            .clear_i   (alarm_clear_i),
            .latched_o (latched_guard_alarm_n[ch]),
            .live_o    (live_guard_alarm_n[ch])
        );
        alarm_flag_pair u_clamp (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .cond_i    (cause_i.clamp_fault[ch]),
            .clear_i   (alarm_clear_i),
            .latched_o (latched_clamp_alarm_n[ch]),
            .live_o    (live_clamp_alarm_n[ch])
        );
    end

    // alarm word and open-drain pins
    logic [23:0] next_alarm_word;
    logic        next_temp_pin_oe;
    logic        next_cg_pin_oe;

    always_comb begin
        next_alarm_word = '0;
        next_alarm_word[TYPE_HI_BIT:TYPE_LO_BIT] = TYPE_ALARM;
        next_alarm_word[TEMP_LATCH_BIT] = latched_temp_alarm;
        next_alarm_word[TEMP_LIVE_BIT]  = live_temp_alarm;
        for (int ch = 0; ch < CHANNELS; ch++) begin
            next_alarm_word[pair_bit(GUARD_TOP_BIT, ch)] =
                latched_guard_alarm_n[ch];
            next_alarm_word[pair_bit(GUARD_TOP_BIT, ch) - 1] =
                live_guard_alarm_n[ch];
            next_alarm_word[pair_bit(CLAMP_TOP_BIT, ch)] =
                latched_clamp_alarm_n[ch];
            next_alarm_word[pair_bit(CLAMP_TOP_BIT, ch) - 1] =
                live_clamp_alarm_n[ch];
        end
        next_temp_pin_oe = latched_temp_alarm;
        next_cg_pin_oe   = |{latched_guard_alarm_n,
                             latched_clamp_alarm_n};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_status_word_o        <= ALARM_RESET;
            temp_alarm_pin_oe_o        <= FLAG_RESET;
            clamp_guard_alarm_pin_oe_o <= FLAG_RESET;
        end else begin
            alarm_status_word_o        <= next_alarm_word;
            temp_alarm_pin_oe_o        <= next_temp_pin_oe;
            clamp_guard_alarm_pin_oe_o <= next_cg_pin_oe;
        end
    end

    // open-drain: only ever pulls low
    always_ff @(posedge clk_i) begin
        temp_alarm_pin_out_o        <= 1'h0;
        clamp_guard_alarm_pin_out_o <= 1'h0;
    end

    // converter readback
    logic [23:0] next_conv_word;
    logic        next_conv_done;
    logic        next_conv_refused;
    logic        kind_ok;

    always_comb begin
        kind_ok = conv_req_i.kind == TYPE_GAIN ||
                  conv_req_i.kind == TYPE_OFFSET ||
                  conv_req_i.kind == TYPE_CODE;
        next_conv_word    = conv_word_o;
        next_conv_done    = 1'h0;
        next_conv_refused = 1'h0;
        if (conv_valid_i && kind_ok) begin
            next_conv_word = {conv_req_i.kind,
                              conv_req_i.converter_select_bits,
                              conv_req_i.converter_contents_bits};
            next_conv_done = 1'h1;
        end else if (conv_valid_i) begin
            next_conv_refused = 1'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_word_o    <= '0;
            conv_done_o    <= 1'h0;
            conv_refused_o <= 1'h0;
        end else begin
            conv_word_o    <= next_conv_word;
            conv_done_o    <= next_conv_done;
            conv_refused_o <= next_conv_refused;
        end
    end

    // checks
    sequence s_temp_event;
        !rst_i && cause_i.temp_code > cause_i.temp_threshold;
    endsequence

    property p_temp_pin;
        @(posedge clk_i) disable iff (rst_i)
        s_temp_event |-> ##2 temp_alarm_pin_oe_o;
    endproperty
    a_temp_pin: assert property (p_temp_pin)
        else $error("temperature pin not pulled");

    property p_temp_bits;
        @(posedge clk_i) disable iff (rst_i)
        s_temp_event |-> ##2 alarm_status_word_o[21:20] == 2'h3;
    endproperty
    a_temp_bits: assert property (p_temp_bits)
        else $error("temperature bits not set");

    property p_latch_holds;
        @(posedge clk_i) disable iff (rst_i)
        !alarm_clear_i ##1 alarm_status_word_o[21] && !alarm_clear_i
        |-> ##2 alarm_status_word_o[21];
    endproperty
    a_latch_holds: assert property (p_latch_holds)
        else $error("latched temperature flag dropped");

    property p_clear;
        @(posedge clk_i) disable iff (rst_i)
        alarm_clear_i && cause_i == '0 ##1 cause_i == '0
        |-> ##1 alarm_status_word_o[21] == 1'h0
            && alarm_status_word_o[19:4] == 16'h0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not reset latched flags");

    property p_guard0;
        @(posedge clk_i) disable iff (rst_i)
        cause_i.guard_fault[0] |-> ##2 alarm_status_word_o[19]
            && clamp_guard_alarm_pin_oe_o;
    endproperty
    a_guard0: assert property (p_guard0)
        else $error("guard fault channel 0 not reported");

    property p_guard3_live;
        @(posedge clk_i) disable iff (rst_i)
        !cause_i.guard_fault[3] |-> ##2 !alarm_status_word_o[12];
    endproperty
    a_guard3_live: assert property (p_guard3_live)
        else $error("live guard flag channel 3 stuck");

    property p_clamp3;
        @(posedge clk_i) disable iff (rst_i)
        cause_i.clamp_fault[3] |-> ##2 alarm_status_word_o[5:4] == 2'h3
            && clamp_guard_alarm_pin_oe_o;
    endproperty
    a_clamp3: assert property (p_clamp3)
        else $error("clamp fault channel 3 not reported");

    property p_conv;
        @(posedge clk_i) disable iff (rst_i)
        conv_valid_i && conv_req_i.kind != 2'h0 |=> conv_done_o
            && conv_word_o == $past(conv_req_i);
    endproperty
    a_conv: assert property (p_conv)
        else $error("converter word wrong");

    property p_conv_refuse;
        @(posedge clk_i) disable iff (rst_i)
        conv_valid_i && conv_req_i.kind == 2'h0 |=> conv_refused_o
            && !conv_done_o && $stable(conv_word_o);
    endproperty
    a_conv_refuse: assert property (p_conv_refuse)
        else $error("illegal type accepted");

    property p_alarm_frame;
        @(posedge clk_i) disable iff (rst_i)
        alarm_status_word_o[23:22] == 2'h3
            && alarm_status_word_o[3:0] == 4'h0;
    endproperty
    a_alarm_frame: assert property (p_alarm_frame)
        else $error("alarm word frame bits wrong");

    property p_reset_value;
        @(posedge clk_i)
        rst_i |=> alarm_status_word_o == 24'hFFFFF0;
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("alarm word reset value wrong");

    // open-drain pins may only pull low
    property p_pins_never_high;
        @(posedge clk_i) disable iff (rst_i)
        !temp_alarm_pin_out_o && !clamp_guard_alarm_pin_out_o;
    endproperty
    a_pins_never_high: assert property (p_pins_never_high)
        else $error("open-drain pin driven high");

    sequence s_temp_calm;
        !rst_i && cause_i.temp_code <= cause_i.temp_threshold;
    endsequence

    property p_temp_live_drop;
        @(posedge clk_i) disable iff (rst_i)
        s_temp_calm |-> ##2 !alarm_status_word_o[20];
    endproperty
    a_temp_live_drop: assert property (p_temp_live_drop)
        else $error("live temperature flag stuck");

    property p_temp_set_wins;
        @(posedge clk_i) disable iff (rst_i)
        alarm_clear_i && temp_over |-> ##2 alarm_status_word_o[21]
            && temp_alarm_pin_oe_o;
    endproperty
    a_temp_set_wins: assert property (p_temp_set_wins)
        else $error("clear beat a live temperature event");

    property p_temp_release;
        @(posedge clk_i) disable iff (rst_i)
        alarm_clear_i ##0 s_temp_calm |-> ##2 !alarm_status_word_o[21]
            && !temp_alarm_pin_oe_o;
    endproperty
    a_temp_release: assert property (p_temp_release)
        else $error("temperature alarm not released by clear");

    property p_shared_release;
        @(posedge clk_i) disable iff (rst_i)
        alarm_clear_i && cause_i.guard_fault == 4'h0
            && cause_i.clamp_fault == 4'h0
            |-> ##2 !clamp_guard_alarm_pin_oe_o;
    endproperty
    a_shared_release: assert property (p_shared_release)
        else $error("shared alarm pin not released by clear");

    property p_conv_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !conv_valid_i |=> !conv_done_o && !conv_refused_o
            && $stable(conv_word_o);
    endproperty
    a_conv_quiet: assert property (p_conv_quiet)
        else $error("converter answer without a request");

    property p_reset_outputs;
        @(posedge clk_i)
        rst_i |=> temp_alarm_pin_oe_o && clamp_guard_alarm_pin_oe_o
            && conv_word_o == 24'h0 && !conv_done_o && !conv_refused_o;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs)
        else $error("outputs not at reset values");

    // every channel's guard and clamp pair
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chk
        localparam int GUARD_BIT = pair_bit(GUARD_TOP_BIT, ch);
        localparam int CLAMP_BIT = pair_bit(CLAMP_TOP_BIT, ch);

        property p_guard_pair;
            @(posedge clk_i) disable iff (rst_i)
            cause_i.guard_fault[ch] |-> ##2 alarm_status_word_o[GUARD_BIT]
                && alarm_status_word_o[GUARD_BIT - 1]
                && clamp_guard_alarm_pin_oe_o;
        endproperty
        a_guard_pair: assert property (p_guard_pair)
            else $error("guard fault not reported on its pair");

        property p_clamp_pair;
            @(posedge clk_i) disable iff (rst_i)
            cause_i.clamp_fault[ch] |-> ##2 alarm_status_word_o[CLAMP_BIT]
                && alarm_status_word_o[CLAMP_BIT - 1]
                && clamp_guard_alarm_pin_oe_o;
        endproperty
        a_clamp_pair: assert property (p_clamp_pair)
            else $error("clamp fault not reported on its pair");

        property p_clamp_live_drop;
            @(posedge clk_i) disable iff (rst_i)
            !cause_i.clamp_fault[ch] |-> ##2 !alarm_status_word_o[CLAMP_BIT - 1];
        endproperty
        a_clamp_live_drop: assert property (p_clamp_live_drop)
            else $error("live clamp flag stuck");

        property p_chan_release;
            @(posedge clk_i) disable iff (rst_i)
            alarm_clear_i && !cause_i.guard_fault[ch] && !cause_i.clamp_fault[ch]
                |-> ##2 !alarm_status_word_o[GUARD_BIT]
                && !alarm_status_word_o[CLAMP_BIT];
        endproperty
        a_chan_release: assert property (p_chan_release)
            else $error("channel latched flags not cleared");
    end
endmodule : alarm_and_dac_readback
`default_nettype wire

// ### design/alarm_readback_pkg.sv
// Summary of operation
// - temperature alarm drives pin and readback flag
// - one temperature alarm, bits 21 and 20
// - latched flag holds, live flag follows temperature
// - clear strobe resets latched alarm flags unless their cause is present that cycle
// - guard pairs from bits 19/18 down to 13/12
// - guard flags mark channel pulling shared pin
// - clamp pairs from bits 11/10 down to 5/4
// - clamp flags mark channel pulling shared pin
// - converter readback is one 24-bit word
// - top bits: 01 gain, 10 offset, 11 code
// - bits 21..16 carry converter register address
// - bits 15..0 carry converter register contents
// - alarm word powers up as FFFFF0
package alarm_readback_pkg;
    localparam int          CHANNELS        = 4;
    localparam int          TEMP_W          = 8;
    localparam int          WORD_W          = 24;
    localparam int          TYPE_HI_BIT     = 23;
    localparam int          TYPE_LO_BIT     = 22;
    localparam int          TEMP_LATCH_BIT  = 21;
    localparam int          TEMP_LIVE_BIT   = 20;
    localparam int          GUARD_TOP_BIT   = 19;
    localparam int          CLAMP_TOP_BIT   = 11;
    localparam int          ADDR_LO_BIT     = 16;
    localparam logic [1:0]  TYPE_GAIN       = 2'h1;
    localparam logic [1:0]  TYPE_OFFSET     = 2'h2;
    localparam logic [1:0]  TYPE_CODE       = 2'h3;
    localparam logic [1:0]  TYPE_ALARM      = 2'h3;
    localparam logic [23:0] ALARM_RESET     = 24'hFFFFF0;
    localparam logic        FLAG_RESET      = 1'h1;

    typedef struct packed {
        logic [TEMP_W-1:0]   temp_code;
        logic [TEMP_W-1:0]   temp_threshold;
        logic [CHANNELS-1:0] guard_fault;
        logic [CHANNELS-1:0] clamp_fault;
    } alarm_cause_t;

    typedef struct packed {
        logic [1:0]  kind;
        logic [5:0]  converter_select_bits;
        logic [15:0] converter_contents_bits;
    } convert_req_t;

    // latched bit of a channel pair; live bit sits one below
    function automatic int pair_bit(input int top, input int ch);
        pair_bit = top - 2 * ch;
    endfunction : pair_bit
endpackage : alarm_readback_pkg

// ### design/alarm_flag_pair.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_flag_pair (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic cond_i,
    input  wire logic clear_i,
    output var  logic latched_o,
    output var  logic live_o
);
    import alarm_readback_pkg::*;

    logic next_latched;
    logic next_live;

    always_comb begin
        next_latched = cond_i | (latched_o & ~clear_i);
        next_live    = cond_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latched_o <= FLAG_RESET;
            live_o    <= FLAG_RESET;
        end else begin
            latched_o <= next_latched;
            live_o    <= next_live;
        end
    end
endmodule : alarm_flag_pair
`default_nettype wire

// ### verif/readback_host.sv
`timescale 1ns/1ps
`default_nettype none
module readback_host (
    input  wire logic                             clk_i,
    input  wire logic [23:0]                      conv_word_i,
    input  wire logic                             conv_done_i,
    input  wire logic                             conv_refused_i,
    output var  logic                             alarm_clear_o,
    output var  logic                             conv_valid_o,
    output var  alarm_readback_pkg::convert_req_t conv_req_o
);
    import alarm_readback_pkg::*;
    initial begin
        alarm_clear_o = 1'h0;
        conv_valid_o  = 1'h0;
        conv_req_o    = '0;
    end
    // one-edge write of the control clear bit
    task automatic clear_alarms;
        alarm_clear_o = 1'h1;
        @(posedge clk_i);
        #1;
        alarm_clear_o = 1'h0;
    endtask : clear_alarms
    // valid left high so requests can run back to back
    task automatic read_conv(input convert_req_t req,
                             output logic [23:0] word,
                             output logic [1:0] ack);
        conv_valid_o = 1'h1;
        conv_req_o   = req;
        @(posedge clk_i);
        #1;
        word = conv_word_i;
        ack  = {conv_done_i, conv_refused_i};
    endtask : read_conv
    task automatic idle;
        conv_valid_o = 1'h0;
        conv_req_o   = ~conv_req_o; // released bus shows no stale value
    endtask : idle
endmodule : readback_host
`default_nettype wire

// ### verif/alarm_and_dac_readback_test.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_and_dac_readback_test;
    import alarm_readback_pkg::*;
    logic         clk_i, rst_i, alarm_clear_i, conv_valid_i;
    logic         conv_done_o, conv_refused_o, t_out, t_oe, cg_out, cg_oe;
    logic [23:0]  alarm_status_word_o, conv_word_o, word;
    logic [1:0]   ack;
    logic [3:0]   one;
    alarm_cause_t cause_i;
    convert_req_t conv_req_i, req, prev;
    int           n_fail, checks_done;

    alarm_and_dac_readback uut (.clk_i(clk_i), .rst_i(rst_i),
        .cause_i(cause_i), .alarm_clear_i(alarm_clear_i),
        .conv_valid_i(conv_valid_i), .conv_req_i(conv_req_i),
        .alarm_status_word_o(alarm_status_word_o),
        .conv_word_o(conv_word_o), .conv_done_o(conv_done_o),
        .conv_refused_o(conv_refused_o),
        .temp_alarm_pin_out_o(t_out), .temp_alarm_pin_oe_o(t_oe),
        .clamp_guard_alarm_pin_out_o(cg_out),
        .clamp_guard_alarm_pin_oe_o(cg_oe));
    readback_host host (.clk_i(clk_i), .conv_word_i(conv_word_o),
        .conv_done_i(conv_done_o), .conv_refused_i(conv_refused_o),
        .alarm_clear_o(alarm_clear_i), .conv_valid_o(conv_valid_i),
        .conv_req_o(conv_req_i));

    task automatic check(input string what, input logic [23:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic chk_al(input logic [1:0] t,
                          input logic [3:0] lg, g, lc, c);
        logic [23:0] w;
        w = {2'h3, t, 20'h0};
        for (int ch = 0; ch < 4; ch++) begin
            w[19-2*ch] = lg[ch];
            w[18-2*ch] = g[ch];
            w[11-2*ch] = lc[ch];
            w[10-2*ch] = c[ch];
        end
        check("alarm word", alarm_status_word_o, w);
        check("temp pin oe", {23'h0, t_oe}, {23'h0, t[1]});
        check("shared pin oe", {23'h0, cg_oe}, {23'h0, |{lg, lc}});
        check("pin outs", {22'h0, t_out, cg_out}, 24'h0);
    endtask : chk_al
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        clk_i = 1'h0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
    initial begin
        n_fail = 0;
        checks_done = 0;
        rst_i = 1'h1;
        cause_i = '0;
        step(12);
        chk_al(2'h3, 4'hF, 4'hF, 4'hF, 4'hF);
        rst_i = 1'h0;
        step(2);
        chk_al(2'h2, 4'hF, 4'h0, 4'hF, 4'h0);
        host.clear_alarms();
        step(1);
        chk_al(2'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        // equal to threshold is not over
        cause_i.temp_threshold = 8'h80;
        cause_i.temp_code = 8'h80;
        step(2);
        chk_al(2'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        cause_i.temp_code = 8'h81;
        step(2);
        chk_al(2'h3, 4'h0, 4'h0, 4'h0, 4'h0);
        host.clear_alarms();
        step(1);
        chk_al(2'h3, 4'h0, 4'h0, 4'h0, 4'h0);
        cause_i.temp_code = 8'h10;
        step(2);
        chk_al(2'h2, 4'h0, 4'h0, 4'h0, 4'h0);
        host.clear_alarms();
        step(1);
        chk_al(2'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        for (int ch = 0; ch < 4; ch++) begin
            one = 4'h1 << ch;
            cause_i.guard_fault = one;
            step(2);
            chk_al(2'h0, one, one, 4'h0, 4'h0);
            cause_i.guard_fault = 4'h0;
            cause_i.clamp_fault = one;
            step(2);
            chk_al(2'h0, one, 4'h0, one, one);
            cause_i.clamp_fault = 4'h0;
            step(2);
            chk_al(2'h0, one, 4'h0, one, 4'h0);
            host.clear_alarms();
            step(1);
            chk_al(2'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        end
        // kinds 01, 10, 11 back to back, then refused kind 00
        for (int k = 1; k < 5; k++) begin
            req = {2'(k), 6'(k * 21), 16'(16'hA5C3 ^ k)};
            host.read_conv(req, word, ack);
            if (k < 4) begin
                check("conv word", word, req);
                check("conv ack", {22'h0, ack}, 24'h2);
                prev = req;
            end else begin
                check("refused word", word, prev);
                check("refused ack", {22'h0, ack}, 24'h1);
            end
        end
        host.idle();
        step(1);
        check("idle ack", {22'h0, conv_done_o, conv_refused_o}, 24'h0);
        final_report();
    end
endmodule : alarm_and_dac_readback_test
`default_nettype wire
